/* inc/cam_restore_pkg.sv */
package cam_restore_pkg;
    // Register byte offsets.
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_METHOD = 8'h04;
    localparam logic [7:0] OFF_MAIN_INIT = 8'h08;
    localparam logic [7:0] OFF_STD_INIT = 8'h0C;
    localparam logic [7:0] OFF_CYCLE_LEN = 8'h10;
    localparam logic [7:0] OFF_TABLE = 8'h14;
    localparam logic [7:0] OFF_STROKE = 8'h18;
    localparam logic [7:0] OFF_CLUTCH = 8'h1C;
    localparam logic [7:0] OFF_COMP = 8'h20;
    localparam logic [7:0] OFF_COMP_TIME = 8'h24;
    localparam logic [7:0] OFF_STATUS = 8'h28;
    localparam logic [7:0] OFF_MAIN_CUR = 8'h2C;
    localparam logic [7:0] OFF_STD_CUR = 8'h30;
    localparam logic [7:0] OFF_CAM_CUR = 8'h34;
    // Field positions inside the method register.
    localparam int MAIN_SEL_LSB = 0;
    localparam int TARGET_SEL_LSB = 4;
    localparam int STD_SEL_LSB = 8;
    localparam int CAM_SEL_LSB = 12;
    localparam int MAIN_UNIT_LSB = 16;
    // Method selector codes.
    localparam logic [1:0] SEL_0 = 2'h0;
    localparam logic [1:0] SEL_1 = 2'h1;
    localparam logic [1:0] SEL_2 = 2'h2;
    // Main shaft input selection codes.
    localparam logic [1:0] UNIT_POSITIONING = 2'h1;
    localparam logic [1:0] UNIT_ENCODER = 2'h2;
    // Standard position range limit.
    localparam logic signed [31:0] STD_LIMIT = 32'sd999999;
    // Reset values.
    localparam logic [31:0] RESET_WORD = 32'h00000000;
    // Bus response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Sequencer states.
    typedef enum logic [2:0] {ST_IDLE, ST_MAIN, ST_STD, ST_CAM, ST_RUN} seq_state_t;
endpackage

/* core/prev_store.sv */
`timescale 1ns/100ps
`default_nettype none
// Volatile holder for a previous value with a valid flag; power loss clears it.
module prev_store
    import cam_restore_pkg::*;
#(
    parameter int WIDTH = 32
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic save,
    input wire logic [WIDTH-1:0] save_value,
    output logic [WIDTH-1:0] value,
    output logic valid
);
    logic [WIDTH-1:0] value_ff;
    logic [WIDTH-1:0] nxt_value;
    logic valid_ff;
    logic nxt_valid;

    // Capture a value on save.
    always_comb begin
        nxt_value = value_ff;
        nxt_valid = valid_ff;
        if (save) begin
            nxt_value = save_value;
            nxt_valid = 1'b1;
        end
    end

    // Register only; reset clears the content.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            value_ff <= WIDTH'(RESET_WORD);
            valid_ff <= 1'b0;
        end else begin
            value_ff <= nxt_value;
            valid_ff <= nxt_valid;
        end
    end

    assign value = value_ff;
    assign valid = valid_ff;
endmodule
`default_nettype wire

/* core/axil_regs.sv */
`timescale 1ns/100ps
`default_nettype none
// AXI4-Lite slave front end: one write and one read at a time.
module axil_regs
    import cam_restore_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wr_en,
    output logic [7:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_ok,
    output logic [7:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_ok
);
    logic aw_ff, nxt_aw, w_ff, nxt_w, b_ff, nxt_b, r_ff, nxt_r;
    logic [7:0] awa_ff, nxt_awa;
    logic [31:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
    logic [3:0] ws_ff, nxt_ws;
    logic [1:0] br_ff, nxt_br, rr_ff, nxt_rr;

    // Address and data are taken in either order; the response follows both.
    always_comb begin
        nxt_aw = aw_ff;
        nxt_w = w_ff;
        nxt_b = b_ff;
        nxt_awa = awa_ff;
        nxt_wd = wd_ff;
        nxt_ws = ws_ff;
        nxt_br = br_ff;
        if (s_axi_awvalid && !aw_ff && !b_ff) begin
            nxt_aw = 1'b1;
            nxt_awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_ff && !b_ff) begin
            nxt_w = 1'b1;
            nxt_wd = s_axi_wdata;
            nxt_ws = s_axi_wstrb;
        end
        if (aw_ff && w_ff) begin
            nxt_aw = 1'b0;
            nxt_w = 1'b0;
            nxt_b = 1'b1;
            nxt_br = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        if (b_ff && s_axi_bready) begin
            nxt_b = 1'b0;
        end
    end

    // Read answers one cycle after the address is taken.
    always_comb begin
        nxt_r = r_ff;
        nxt_rd = rd_ff;
        nxt_rr = rr_ff;
        if (s_axi_arvalid && !r_ff) begin
            nxt_r = 1'b1;
            nxt_rd = rd_ok ? rd_data : RESET_WORD;
            nxt_rr = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (r_ff && s_axi_rready) begin
            nxt_r = 1'b0;
        end
    end

    // Register the channel state.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            b_ff <= 1'b0;
            r_ff <= 1'b0;
            awa_ff <= 8'h00;
            wd_ff <= RESET_WORD;
            ws_ff <= 4'h0;
            br_ff <= RESP_OKAY;
            rd_ff <= RESET_WORD;
            rr_ff <= RESP_OKAY;
        end else begin
            aw_ff <= nxt_aw;
            w_ff <= nxt_w;
            b_ff <= nxt_b;
            r_ff <= nxt_r;
            awa_ff <= nxt_awa;
            wd_ff <= nxt_wd;
            ws_ff <= nxt_ws;
            br_ff <= nxt_br;
            rd_ff <= nxt_rd;
            rr_ff <= nxt_rr;
        end
    end

    assign s_axi_awready = s_axi_awvalid && !aw_ff && !b_ff;
    assign s_axi_wready = s_axi_wvalid && !w_ff && !b_ff;
    assign s_axi_bvalid = b_ff;
    assign s_axi_bresp = br_ff;
    assign s_axi_arready = s_axi_arvalid && !r_ff;
    assign s_axi_rvalid = r_ff;
    assign s_axi_rdata = rd_ff;
    assign s_axi_rresp = rr_ff;
    assign wr_en = aw_ff && w_ff;
    assign wr_addr = awa_ff;
    assign wr_data = wd_ff;
    assign wr_strb = ws_ff;
    assign rd_addr = s_axi_araddr;
endmodule
`default_nettype wire

/* core/cam_position_restoration.sv */
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Switch-updated settings are latched only when cam control is switched on.
// - Main cycle start: 0 previous, 1 initial value, 2 from input axis.
// - Restore target: 0 cam cycle value, 1 standard position, 2 feed value; 2 is handled like 1, no feed value is restored.
// - Standard position source: 0 feed value, 1 initial value, 2 previous.
// - Keep last standard position; use feed value when none was saved.
// - Previous values are volatile and cleared after power loss.
// - Cam cycle source: 0 previous, 1 initial value, 2 main cycle value.
// - Keep last run's cam cycle value as the next previous value.
// - Main initial value unit follows positioning or encoder unit by input selection.
// - Main initial value accepted only from zero to cycle length minus one.
// - Compensation and clutch smoothing use time constants in milliseconds.
// - Standard initial value used only for method 1, within plus minus 999999.
module cam_position_restoration
    import cam_restore_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] input_axis_pos,
    input wire logic [31:0] feed_current_value,
    input wire logic [31:0] cam_cycle_run_value,
    output logic cam_output_enable,
    output logic [31:0] main_cycle_out,
    output logic [31:0] cam_cycle_out,
    output logic [31:0] std_pos_out,
    output logic [1:0] main_unit_source,
    output logic [31:0] cam_cycle_length,
    output logic [15:0] cam_table_number,
    output logic [31:0] cam_stroke_amount,
    output logic [1:0] clutch_smooth_method,
    output logic [15:0] clutch_smooth_time,
    output logic [31:0] comp_target_position,
    output logic [15:0] comp_time_constant
);
    // Software-side settings; these become active only at a switch.
    logic [31:0] ctrl_ff, nxt_ctrl, method_ff, nxt_method;
    logic [31:0] main_init_ff, nxt_main_init, std_init_ff, nxt_std_init;
    logic [31:0] len_ff, nxt_len, table_ff, nxt_table, stroke_ff, nxt_stroke;
    logic [31:0] clutch_ff, nxt_clutch, comp_ff, nxt_comp, ctime_ff, nxt_ctime;
    logic wr_en, wr_ok, rd_ok;
    logic [7:0] wr_addr, rd_addr;
    logic [31:0] wr_data, rd_data;
    logic [3:0] wr_strb;
    logic [31:0] main_prev, std_prev, cam_prev;
    logic main_prev_ok, std_prev_ok, cam_prev_ok;
    logic save_std, save_cam, save_main;
    logic [31:0] cam_saved;
    // Active copies latched at the switch.
    logic [31:0] a_method_ff, nxt_a_method, a_main_init_ff, nxt_a_main_init;
    logic [31:0] a_std_init_ff, nxt_a_std_init;
    logic [31:0] a_len_ff, nxt_a_len, a_table_ff, nxt_a_table;
    logic [31:0] a_stroke_ff, nxt_a_stroke, a_clutch_ff, nxt_a_clutch;
    logic [31:0] a_comp_ff, nxt_a_comp, a_ctime_ff, nxt_a_ctime;
    logic [31:0] main_ff, nxt_main, std_ff, nxt_std, cam_ff, nxt_cam;
    logic run_ff, nxt_run, enable_d_ff, nxt_enable_d, range_err_ff, nxt_range_err;
    seq_state_t state_ff, nxt_state;
    logic [1:0] main_sel, target_sel, std_sel, cam_sel;
    logic switch_on, switch_off;
    logic signed [31:0] std_init_s;

    axil_regs u_bus (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data), .wr_strb(wr_strb), .wr_ok(wr_ok),
        .rd_addr(rd_addr), .rd_data(rd_data), .rd_ok(rd_ok)
    );

    // Previous values live in reset-cleared flops only.
    prev_store #(.WIDTH(32)) u_prev_main (
        .aclk(aclk), .aresetn(aresetn), .save(save_main), .save_value(main_ff),
        .value(main_prev), .valid(main_prev_ok)
    );
    prev_store #(.WIDTH(32)) u_prev_std (
        .aclk(aclk), .aresetn(aresetn), .save(save_std), .save_value(std_ff),
        .value(std_prev), .valid(std_prev_ok)
    );
    prev_store #(.WIDTH(32)) u_prev_cam (
        .aclk(aclk), .aresetn(aresetn), .save(save_cam), .save_value(cam_saved),
        .value(cam_prev), .valid(cam_prev_ok)
    );

    // Byte-lane merge helper for register writes.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Register writes; status and current values are read-only.
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_method = method_ff;
        nxt_main_init = main_init_ff;
        nxt_std_init = std_init_ff;
        nxt_len = len_ff;
        nxt_table = table_ff;
        nxt_stroke = stroke_ff;
        nxt_clutch = clutch_ff;
        nxt_comp = comp_ff;
        nxt_ctime = ctime_ff;
        wr_ok = 1'b1;
        if (wr_en) begin
            unique case (wr_addr)
                OFF_CTRL: nxt_ctrl = merge(ctrl_ff, wr_data, wr_strb);
                OFF_METHOD: nxt_method = merge(method_ff, wr_data, wr_strb);
                OFF_MAIN_INIT: nxt_main_init = merge(main_init_ff, wr_data, wr_strb);
                OFF_STD_INIT: nxt_std_init = merge(std_init_ff, wr_data, wr_strb);
                OFF_CYCLE_LEN: nxt_len = merge(len_ff, wr_data, wr_strb);
                OFF_TABLE: nxt_table = merge(table_ff, wr_data, wr_strb);
                OFF_STROKE: nxt_stroke = merge(stroke_ff, wr_data, wr_strb);
                OFF_CLUTCH: nxt_clutch = merge(clutch_ff, wr_data, wr_strb);
                OFF_COMP: nxt_comp = merge(comp_ff, wr_data, wr_strb);
                OFF_COMP_TIME: nxt_ctime = merge(ctime_ff, wr_data, wr_strb);
                OFF_STATUS, OFF_MAIN_CUR, OFF_STD_CUR, OFF_CAM_CUR: wr_ok = 1'b1;
                default: wr_ok = 1'b0;
            endcase
        end
    end

    // Register read mux.
    always_comb begin
        rd_data = RESET_WORD;
        rd_ok = 1'b1;
        unique case (rd_addr)
            OFF_CTRL: rd_data = ctrl_ff;
            OFF_METHOD: rd_data = method_ff;
            OFF_MAIN_INIT: rd_data = main_init_ff;
            OFF_STD_INIT: rd_data = std_init_ff;
            OFF_CYCLE_LEN: rd_data = len_ff;
            OFF_TABLE: rd_data = table_ff;
            OFF_STROKE: rd_data = stroke_ff;
            OFF_CLUTCH: rd_data = clutch_ff;
            OFF_COMP: rd_data = comp_ff;
            OFF_COMP_TIME: rd_data = ctime_ff;
            OFF_STATUS: rd_data = {26'h0, std_prev_ok, cam_prev_ok, main_prev_ok,
                                   range_err_ff, run_ff, state_ff == ST_IDLE};
            OFF_MAIN_CUR: rd_data = main_ff;
            OFF_STD_CUR: rd_data = std_ff;
            OFF_CAM_CUR: rd_data = cam_ff;
            default: rd_ok = 1'b0;
        endcase
    end

    assign switch_on = ctrl_ff[0] && !enable_d_ff;
    assign switch_off = !ctrl_ff[0] && enable_d_ff;
    assign main_sel = a_method_ff[MAIN_SEL_LSB +: 2];
    assign target_sel = a_method_ff[TARGET_SEL_LSB +: 2];
    assign std_sel = a_method_ff[STD_SEL_LSB +: 2];
    assign cam_sel = a_method_ff[CAM_SEL_LSB +: 2];
    assign std_init_s = $signed(a_std_init_ff);
    // The cam value of a run is saved at its end, or when a run is replaced.
    assign cam_saved = cam_cycle_run_value;
    assign save_cam = run_ff && (switch_off || switch_on);
    assign save_std = state_ff == ST_CAM;
    assign save_main = switch_off && run_ff;

    // Switch-time latch and restoration sequencer.
    always_comb begin
        nxt_enable_d = ctrl_ff[0];
        nxt_a_method = a_method_ff;
        nxt_a_main_init = a_main_init_ff;
        nxt_a_std_init = a_std_init_ff;
        nxt_a_len = a_len_ff;
        nxt_a_table = a_table_ff;
        nxt_a_stroke = a_stroke_ff;
        nxt_a_clutch = a_clutch_ff;
        nxt_a_comp = a_comp_ff;
        nxt_a_ctime = a_ctime_ff;
        nxt_state = state_ff;
        nxt_main = main_ff;
        nxt_std = std_ff;
        nxt_cam = cam_ff;
        nxt_run = run_ff;
        nxt_range_err = range_err_ff;
        if (switch_on) begin
            nxt_a_method = method_ff;
            nxt_a_main_init = main_init_ff;
            nxt_a_std_init = std_init_ff;
            nxt_a_len = len_ff;
            nxt_a_table = table_ff;
            nxt_a_stroke = stroke_ff;
            nxt_a_clutch = clutch_ff;
            nxt_a_comp = comp_ff;
            nxt_a_ctime = ctime_ff;
            nxt_range_err = 1'b0;
            nxt_run = 1'b0;
            nxt_state = ST_MAIN;
        end else if (switch_off) begin
            nxt_run = 1'b0;
            nxt_state = ST_IDLE;
        end else begin
            unique case (state_ff)
                ST_IDLE: nxt_state = ST_IDLE;
                ST_MAIN: begin
                    unique case (main_sel)
                        SEL_1: begin
                            if (a_main_init_ff < a_len_ff) begin
                                nxt_main = a_main_init_ff;
                            end else begin
                                nxt_main = RESET_WORD;
                                nxt_range_err = 1'b1;
                            end
                        end
                        SEL_2: nxt_main = (a_len_ff == RESET_WORD) ? input_axis_pos
                                          : input_axis_pos % a_len_ff;
                        default: nxt_main = main_prev_ok ? main_prev : RESET_WORD;
                    endcase
                    nxt_state = ST_STD;
                end
                ST_STD: begin
                    if (target_sel == SEL_0) begin
                        nxt_std = std_ff;
                    end else begin
                        unique case (std_sel)
                            SEL_1: begin
                                if (std_init_s > STD_LIMIT || std_init_s < -STD_LIMIT) begin
                                    nxt_std = feed_current_value;
                                    nxt_range_err = 1'b1;
                                end else begin
                                    nxt_std = a_std_init_ff;
                                end
                            end
                            SEL_2: nxt_std = std_prev_ok ? std_prev : feed_current_value;
                            default: nxt_std = feed_current_value;
                        endcase
                    end
                    nxt_state = ST_CAM;
                end
                ST_CAM: begin
                    if (target_sel == SEL_0) begin
                        nxt_cam = cam_prev_ok ? cam_prev : RESET_WORD;
                    end else begin
                        unique case (cam_sel)
                            SEL_1: nxt_cam = a_main_init_ff;
                            SEL_2: nxt_cam = main_ff;
                            default: nxt_cam = cam_prev_ok ? cam_prev : RESET_WORD;
                        endcase
                    end
                    nxt_state = ST_RUN;
                end
                ST_RUN: nxt_run = 1'b1;
                default: nxt_state = ST_IDLE;
            endcase
        end
    end

    // Register the sequencer, active copies and restored values.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= RESET_WORD;
            method_ff <= RESET_WORD;
            main_init_ff <= RESET_WORD;
            std_init_ff <= RESET_WORD;
            len_ff <= RESET_WORD;
            table_ff <= RESET_WORD;
            stroke_ff <= RESET_WORD;
            clutch_ff <= RESET_WORD;
            comp_ff <= RESET_WORD;
            ctime_ff <= RESET_WORD;
            a_method_ff <= RESET_WORD;
            a_main_init_ff <= RESET_WORD;
            a_std_init_ff <= RESET_WORD;
            a_len_ff <= RESET_WORD;
            a_table_ff <= RESET_WORD;
            a_stroke_ff <= RESET_WORD;
            a_clutch_ff <= RESET_WORD;
            a_comp_ff <= RESET_WORD;
            a_ctime_ff <= RESET_WORD;
            main_ff <= RESET_WORD;
            std_ff <= RESET_WORD;
            cam_ff <= RESET_WORD;
            run_ff <= 1'b0;
            enable_d_ff <= 1'b0;
            range_err_ff <= 1'b0;
            state_ff <= ST_IDLE;
        end else begin
            ctrl_ff <= nxt_ctrl;
            method_ff <= nxt_method;
            main_init_ff <= nxt_main_init;
            std_init_ff <= nxt_std_init;
            len_ff <= nxt_len;
            table_ff <= nxt_table;
            stroke_ff <= nxt_stroke;
            clutch_ff <= nxt_clutch;
            comp_ff <= nxt_comp;
            ctime_ff <= nxt_ctime;
            a_method_ff <= nxt_a_method;
            a_main_init_ff <= nxt_a_main_init;
            a_std_init_ff <= nxt_a_std_init;
            a_len_ff <= nxt_a_len;
            a_table_ff <= nxt_a_table;
            a_stroke_ff <= nxt_a_stroke;
            a_clutch_ff <= nxt_a_clutch;
            a_comp_ff <= nxt_a_comp;
            a_ctime_ff <= nxt_a_ctime;
            main_ff <= nxt_main;
            std_ff <= nxt_std;
            cam_ff <= nxt_cam;
            run_ff <= nxt_run;
            enable_d_ff <= nxt_enable_d;
            range_err_ff <= nxt_range_err;
            state_ff <= nxt_state;
        end
    end

    // Outputs straight from flops; time constants are in milliseconds.
    assign cam_output_enable = run_ff;
    assign main_cycle_out = main_ff;
    assign std_pos_out = std_ff;
    assign cam_cycle_out = cam_ff;
    assign main_unit_source = a_method_ff[MAIN_UNIT_LSB +: 2];
    assign cam_cycle_length = a_len_ff;
    assign cam_table_number = a_table_ff[15:0];
    assign cam_stroke_amount = a_stroke_ff;
    assign clutch_smooth_method = a_clutch_ff[1:0];
    assign clutch_smooth_time = a_clutch_ff[31:16];
    assign comp_target_position = a_comp_ff;
    assign comp_time_constant = a_ctime_ff[15:0];
endmodule
`default_nettype wire

/* bench/axis_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Far-side axes at fixed positions so each restored value is known in advance.
module axis_model (
    output logic [31:0] input_axis_pos,
    output logic [31:0] feed_current_value,
    output logic [31:0] cam_cycle_run_value
);
    // Input axis 250, feed value 123, run value 77.
    assign input_axis_pos = 32'h000000FA;
    assign feed_current_value = 32'h0000007B;
    assign cam_cycle_run_value = 32'h0000004D;
endmodule
`default_nettype wire

/* bench/cam_position_restoration_checker.sv */
`timescale 1ns/100ps
`default_nettype none
// Watches write answers and the restoration sequence.
module cam_position_restoration_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic cam_output_enable,
    input wire logic [31:0] main_cycle_out,
    input wire logic [31:0] std_pos_out,
    input wire logic [31:0] cam_cycle_length,
    input wire logic [15:0] cam_table_number
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_up; !cam_output_enable ##5 cam_output_enable; endsequence
    property p_latch; $changed(cam_table_number) |-> s_up; endproperty
    a_latch: assert property (p_latch) else $error("latch off switch");
    property p_keep; cam_output_enable [*2] |-> $stable(cam_table_number); endproperty
    a_keep: assert property (p_keep) else $error("copy moved");
    property p_order; $rose(cam_output_enable) |-> $stable(main_cycle_out); endproperty
    a_order: assert property (p_order) else $error("output before resolve");
    property p_range;
        cam_output_enable && cam_cycle_length != 32'h0 |-> main_cycle_out < cam_cycle_length;
    endproperty
    a_range: assert property (p_range) else $error("main out of range");
    property p_clear; $rose(aresetn) |-> !cam_output_enable && std_pos_out == 32'h0; endproperty
    a_clear: assert property (p_clear) else $error("not cleared");
    property p_bans; s_axi_awready && s_axi_wready |-> ##[1:3] s_axi_bvalid; endproperty
    a_bans: assert property (p_bans) else $error("no write answer");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bhold: assert property (p_bhold) else $error("answer dropped");
    property p_noaw; s_axi_bvalid |-> !s_axi_awready; endproperty
    a_noaw: assert property (p_noaw) else $error("address taken early");
endmodule
bind cam_position_restoration cam_position_restoration_checker i_chk (.*);
`default_nettype wire

/* bench/test_cam_position_restoration.sv */
`timescale 1ns/100ps
`default_nettype none
module test_cam_position_restoration
    import cam_restore_pkg::*;
;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, ad, wd;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready;
    logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cam_output_enable;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, main_unit_source, clutch_smooth_method, resp;
    logic [15:0] cam_table_number, clutch_smooth_time, comp_time_constant;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, main_cycle_out, cam_cycle_out, std_pos_out;
    logic [31:0] cam_cycle_length, cam_stroke_amount, comp_target_position;
    logic [31:0] input_axis_pos, feed_current_value, cam_cycle_run_value;
    int err_total = 0, check_count = 0;
    cam_position_restoration i_dut (.*);
    axis_model i_axes (.*);
    // Clock of 100 ns period.
    always #50 aclk = ~aclk;
    // Compares a value with its expectation.
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Prints the verdict and ends the run.
    task end_sim;
        if (err_total == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Offers address and data together and releases each once taken.
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        {ad, wd} = 2'h0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (!(ad && wd)) begin
            @(negedge aclk);
            {ad, wd} = {ad | s_axi_awready, wd | s_axi_wready};
            @(posedge aclk);
            {s_axi_awvalid, s_axi_wvalid} <= {!ad, !wd};
        end
        do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask
    // Switches cam control off and on with method word m; w picks the output.
    task run(input logic [31:0] m, input int w, input logic [31:0] ex);
        wr(OFF_CTRL, 32'h0);
        wr(OFF_METHOD, m);
        wr(OFF_CTRL, 32'h1);
        repeat (8) @(negedge aclk);
        chk(cam_output_enable, 32'h1);
        chk(w == 0 ? main_cycle_out : w == 1 ? std_pos_out : cam_cycle_out, ex);
    endtask
    // Standard position sources, saved value and range.
    task t_std;
        wr(8'h3C, 32'h1);
        chk(resp, RESP_SLVERR);
        wr(OFF_CYCLE_LEN, 32'h64);
        run(32'h210, 1, 32'h7B);
        wr(OFF_STD_INIT, 32'hFFFFFFFB);
        run(32'h110, 1, 32'hFFFFFFFB);
        run(32'h210, 1, 32'hFFFFFFFB);
        run(32'h10, 1, 32'h7B);
        wr(OFF_STD_INIT, 32'hF4240);
        run(32'h110, 1, 32'h7B);
    endtask
    // Main cycle start codes, input selection and range.
    task t_main;
        wr(OFF_MAIN_INIT, 32'h64);
        run(32'h1, 0, 32'h0);
        wr(OFF_MAIN_INIT, 32'h2A);
        run(32'h10001, 0, 32'h2A);
        chk(main_unit_source, UNIT_POSITIONING);
        run(32'h20002, 0, 32'h32);
        chk(main_unit_source, UNIT_ENCODER);
        run(32'h0, 0, 32'h32);
    endtask
    // Cam cycle sources and every restore target.
    task t_cam;
        run(32'h1011, 2, 32'h2A);
        run(32'h2012, 2, 32'h32);
        run(32'h10, 2, 32'h4D);
        run(32'h2021, 2, 32'h2A);
        run(32'h0, 2, 32'h4D);
    endtask
    // Settings wait for the next switch; reset clears previous values.
    task t_latch;
        wr(OFF_TABLE, 32'h9);
        wr(OFF_COMP_TIME, 32'h1F4);
        chk(cam_table_number, 32'h0);
        run(32'h0, 2, 32'h4D);
        chk(cam_table_number, 32'h9);
        chk(comp_time_constant, 32'h1F4);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        run(32'h0, 2, 32'h0);
    endtask
    // Reset, then the scenarios in turn.
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_std;
        t_main;
        t_cam;
        t_latch;
        end_sim;
    end
    // Cuts a hung run short.
    initial begin
        repeat (5000) @(posedge aclk);
        err_total++;
        end_sim;
    end
endmodule
`default_nettype wire
